// ---- rtl/dio_pkg.sv ----
package dio_pkg;

    // timing from the core clock; setup and hold round up, never down
    localparam int CLK_PERIOD_NS = 40;
    localparam logic [9:0] SETUP_LAST = 10'((360 - 1) / CLK_PERIOD_NS);
    localparam logic [9:0] HOLD_LAST = 10'((300 - 1) / CLK_PERIOD_NS);
    localparam logic [9:0] ABORT_LAST = 10'(40000 / CLK_PERIOD_NS - 1);
    localparam logic [4:0] FRC_LAST = 5'(1000000 / CLK_PERIOD_NS / 2048 - 1);

    // controller register map (byte addresses)
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_ADDR = 5'h04;
    localparam logic [4:0] REG_WDATA = 5'h08;
    localparam logic [4:0] REG_RDATA = 5'h0C;
    localparam logic [4:0] REG_STATUS = 5'h10;

    // control register fields
    localparam int CTRL_GO = 0;
    localparam int CTRL_WRITE = 1;
    localparam int CTRL_RF_LSB = 2;
    localparam int CTRL_VAR16 = 6;
    localparam int CTRL_OPRESET = 7;

    // status register fields
    localparam int ST_BUSY = 0;
    localparam int ST_CC_A = 1;
    localparam int ST_CC_B = 2;
    localparam int ST_OVF = 3;
    localparam int ST_CARRY = 4;
    localparam int ST_ABORT = 5;
    localparam int ST_DONE = 6;
    localparam int ST_REFUSED = 7;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        MODE_INTERNAL = 4'h0,
        MODE_INTERRUPT = 4'h1,
        MODE_TESTER = 4'h2,
        MODE_SPECIAL = 4'hF
    } dio_mode_type;

    typedef enum logic [2:0] {
        CS_IDLE = 3'b000,
        CS_SETUP = 3'b001,
        CS_STROBE = 3'b010,
        CS_HOLD = 3'b011,
        CS_RELEASE = 3'b100
    } dio_cpu_state_type;

    typedef enum logic {
        US_WAIT = 1'b0,
        US_ACK = 1'b1
    } dio_unit_state_type;

endpackage

// ---- rtl/dio_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface dio_if;
    logic [15:0] address_lines;
    logic direction_line;
    logic [31:0] data_out;
    logic [31:0] data_in;
    logic transfer_strobe;
    logic transfer_acknowledge;
    logic status_bit_a_line;
    logic status_bit_b_line;
    logic io_reset_line;
    logic free_running_clock_line;

    modport cpu_end (
        output address_lines, direction_line, data_out, transfer_strobe,
        output io_reset_line, free_running_clock_line,
        input data_in, transfer_acknowledge,
        input status_bit_a_line, status_bit_b_line
    );
    modport unit_end (
        input address_lines, direction_line, data_out, transfer_strobe,
        input io_reset_line, free_running_clock_line,
        output data_in, transfer_acknowledge,
        output status_bit_a_line, status_bit_b_line
    );
endinterface
`default_nettype wire

// ---- rtl/dio_unit_end.sv ----
`timescale 1ns/1ps
`default_nettype none
module dio_unit_end #(
    parameter logic [15:0] UNIT_ADDR = 16'hF000
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // link
    dio_if.unit_end dio,
    // user side
    output logic xfer_valid,
    output logic xfer_write,
    output logic [15:0] xfer_addr,
    output logic [31:0] xfer_wdata,
    input wire logic [31:0] read_data,
    input wire logic status_a,
    input wire logic status_b,
    output logic io_reset,
    output logic clock_tick
);
    import dio_pkg::*;

    logic [51:0] sync1;
    logic [51:0] sync2;
    logic strobe_q;
    logic frc_q;
    dio_unit_state_type state;

    // every link input is asynchronous to aclk
    wire [51:0] pins = {dio.transfer_strobe, dio.direction_line,
        dio.io_reset_line, dio.free_running_clock_line,
        dio.address_lines, dio.data_out};
    wire strobe_s = sync2[51];
    wire dir_s = sync2[50];
    wire reset_s = sync2[49];
    wire frc_s = sync2[48];
    wire [15:0] addr_s = sync2[47:32];
    wire [31:0] data_s = sync2[31:0];
    wire strobe_rise = strobe_s && !strobe_q;
    wire selected = strobe_rise && (addr_s == UNIT_ADDR) && !reset_s;

    always_ff @(posedge aclk) begin
        sync1 <= pins; // [R20]
        sync2 <= sync1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strobe_q <= 1'b0;
            frc_q <= 1'b0;
            io_reset <= 1'b0;
            clock_tick <= 1'b0;
        end else begin
            strobe_q <= strobe_s;
            frc_q <= frc_s;
            io_reset <= reset_s;
            clock_tick <= frc_s && !frc_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || reset_s) begin
            state <= US_WAIT;
            dio.transfer_acknowledge <= 1'b0;
            dio.data_in <= 32'h0;
            dio.status_bit_a_line <= 1'b0;
            dio.status_bit_b_line <= 1'b0;
            xfer_valid <= 1'b0;
            xfer_write <= 1'b0;
            xfer_addr <= 16'h0;
            xfer_wdata <= 32'h0;
        end else begin
            xfer_valid <= 1'b0;
            case (state)
                US_WAIT: begin
                    // only our own address is answered
                    if (selected) begin // [R02]
                        state <= US_ACK;
                        dio.transfer_acknowledge <= 1'b1;
                        dio.data_in <= dir_s ? 32'h0 : read_data; // [R16]
                        dio.status_bit_a_line <= status_a; // [R05]
                        dio.status_bit_b_line <= status_b;
                        xfer_valid <= 1'b1;
                        xfer_write <= dir_s;
                        xfer_addr <= addr_s;
                        xfer_wdata <= dir_s ? data_s : 32'h0;
                    end
                end
                US_ACK: begin
                    // withdraw everything at once on strobe fall
                    if (!strobe_s) begin // [R04] [R18]
                        state <= US_WAIT;
                        dio.transfer_acknowledge <= 1'b0;
                        dio.data_in <= 32'h0;
                        dio.status_bit_a_line <= 1'b0;
                        dio.status_bit_b_line <= 1'b0;
                    end
                end
                default: state <= US_WAIT;
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- rtl/dio_cpu_end.sv ----
// Function
// (R01) lines set, strobe at least 360 ns later
// (R02) only the addressed unit acknowledges
// (R03) strobe drops at least 300 ns after acknowledge
// (R04) unit withdraws all signals on strobe fall
// (R05) two status bits, addressed unit only
// (R06) io reset on power sequence, operator reset
// (R07) free-running 1.024 MHz square clock; code toggles every 12 clocks, a 960 ns period
// (R08) read puts low 16 address bits
// (R09) read stores data unless field zero
// (R10) 16-bit read: 16 bits, overflow and carry
// (R11) write puts low 16 address bits
// (R12) write drives register or zeros
// (R13) write also samples the status bits
// (R14) 16-bit write: 16 bits, overflow and carry
// (R15) top nibble selects mode, interrupt write-only
// (R16) direction high for write, low read
// (R17) busy stalls further orders, watchdog flag
// (R18) unit drops acknowledge as strobe drops
// (R19) strobe held; 16-bit variant aborts 40 us
// (R20) unit synchronises the strobe twice
`timescale 1ns/1ps
`default_nettype none
module dio_cpu_end (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // power sequencing
    input wire logic power_sequence,
    // link
    dio_if.cpu_end dio
);
    import dio_pkg::*;

    logic aw_held;
    logic w_held;
    logic [4:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic ctrl_write;
    logic [3:0] ctrl_rfield;
    logic ctrl_var16;
    logic ctrl_opreset;
    logic [31:0] eff_addr;
    logic [31:0] wdata_reg;
    logic [31:0] rdata_reg;
    logic cc_a, cc_b, ovf, carry, abort_flag, done_flag, refused_flag;
    dio_cpu_state_type state;
    logic [9:0] cnt;
    logic [4:0] frc_cnt;
    logic [34:0] sync1;
    logic [34:0] sync2;
    logic [31:0] wmask;

    // byte lanes
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign wmask[gi*8 +: 8] = {8{w_strb[gi]}};
        end
    endgenerate

    wire do_write = aw_held && w_held && !s_axi_bvalid;
    wire hit_ctrl = aw_addr == REG_CTRL;
    wire hit_addr = aw_addr == REG_ADDR;
    wire hit_wdata = aw_addr == REG_WDATA;
    wire wr_mapped = hit_ctrl || hit_addr || hit_wdata;
    wire busy = state != CS_IDLE;
    wire ctrl_wr = do_write && hit_ctrl && w_strb[0];
    wire go_req = ctrl_wr && w_data[CTRL_GO] && !busy; // [R17]
    wire go_write = w_data[CTRL_WRITE];
    wire [3:0] go_rfield = w_data[CTRL_RF_LSB +: 4];
    wire go_var16 = w_data[CTRL_VAR16];
    // interrupt control takes writes only
    wire go_bad = (eff_addr[15:12] == MODE_INTERRUPT) && !go_write; // [R15]
    wire go_ok = go_req && !go_bad;
    wire [31:0] out_data = (go_rfield == 4'h0) ? 32'h0 : // [R12]
        (go_var16 ? {16'h0, wdata_reg[15:0]} : wdata_reg); // [R14]
    wire [31:0] status_word = {24'h0, refused_flag, done_flag, abort_flag,
        carry, ovf, cc_b, cc_a, busy};
    wire [4:0] ar_off = s_axi_araddr[4:0];
    wire rd_mapped = s_axi_araddr[31:5] == 27'h0 && ar_off[1:0] == 2'h0 &&
        ar_off <= REG_STATUS;
    wire [31:0] ctrl_word = {24'h0, ctrl_opreset, ctrl_var16, ctrl_rfield,
        ctrl_write, 1'b0};
    wire [31:0] rd_mux = (ar_off == REG_CTRL) ? ctrl_word :
        (ar_off == REG_ADDR) ? eff_addr :
        (ar_off == REG_WDATA) ? wdata_reg :
        (ar_off == REG_RDATA) ? rdata_reg :
        (ar_off == REG_STATUS) ? status_word : 32'h0;

    // link returns are asynchronous
    wire ack_s = sync2[34];
    wire sta_s = sync2[33];
    wire stb_s = sync2[32];
    wire [31:0] din_s = sync2[31:0];

    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        sync1 <= {dio.transfer_acknowledge, dio.status_bit_a_line,
            dio.status_bit_b_line, dio.data_in};
        sync2 <= sync1;
    end

    // write channel: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 5'h0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_held) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr[31:5] == 27'h0 ?
                    s_axi_awaddr[4:0] : 5'h1F;
            end
            if (s_axi_wvalid && !w_held) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // order registers; a transfer in flight freezes all but the operator reset bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            eff_addr <= 32'h0;
            wdata_reg <= 32'h0;
            ctrl_write <= 1'b0;
            ctrl_rfield <= 4'h0;
            ctrl_var16 <= 1'b0;
            ctrl_opreset <= 1'b0;
        end else if (do_write) begin
            if (hit_addr && !busy) begin
                eff_addr <= (eff_addr & ~wmask) | (w_data & wmask);
            end
            if (hit_wdata && !busy) begin
                wdata_reg <= (wdata_reg & ~wmask) | (w_data & wmask);
            end
            if (ctrl_wr) begin
                ctrl_opreset <= w_data[CTRL_OPRESET];
                if (!busy) begin
                    ctrl_write <= go_write;
                    ctrl_rfield <= go_rfield;
                    ctrl_var16 <= go_var16;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dio.io_reset_line <= 1'b1;
        end else begin
            dio.io_reset_line <= power_sequence || ctrl_opreset; // [R06]
        end
    end

    // free-running clock: never gated by transfers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            frc_cnt <= 5'h0;
            dio.free_running_clock_line <= 1'b0;
        end else if (frc_cnt == FRC_LAST) begin
            frc_cnt <= 5'h0;
            dio.free_running_clock_line <= !dio.free_running_clock_line; // [R07]
        end else begin
            frc_cnt <= frc_cnt + 5'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= CS_IDLE;
            cnt <= 10'h0;
            dio.transfer_strobe <= 1'b0;
            dio.address_lines <= 16'h0;
            dio.direction_line <= 1'b0;
            dio.data_out <= 32'h0;
            rdata_reg <= 32'h0;
            {cc_a, cc_b, ovf, carry} <= 4'h0;
            {abort_flag, done_flag, refused_flag} <= 3'h0;
        end else begin
            case (state)
                CS_IDLE: begin
                    if (go_req) begin
                        {abort_flag, done_flag} <= 2'h0;
                        refused_flag <= go_bad;
                    end
                    if (go_ok) begin
                        state <= CS_SETUP;
                        cnt <= 10'h0;
                        dio.address_lines <= eff_addr[15:0]; // [R08] [R11]
                        dio.direction_line <= go_write; // [R16]
                        dio.data_out <= go_write ? out_data : 32'h0;
                    end
                end
                CS_SETUP: begin
                    cnt <= cnt + 10'h1;
                    if (cnt == SETUP_LAST) begin
                        state <= CS_STROBE; // [R01]
                        cnt <= 10'h0;
                        dio.transfer_strobe <= 1'b1;
                    end
                end
                CS_STROBE: begin
                    cnt <= cnt + 10'h1;
                    if (ack_s) begin
                        state <= CS_HOLD;
                        cnt <= 10'h0;
                        if (ctrl_var16) begin
                            ovf <= sta_s; // [R10] [R14]
                            carry <= stb_s;
                        end else begin
                            cc_a <= sta_s; // [R09] [R13]
                            cc_b <= stb_s;
                        end
                        if (!ctrl_write && ctrl_rfield != 4'h0) begin
                            rdata_reg <= ctrl_var16 ? // [R09] [R10]
                                {16'h0, din_s[15:0]} : din_s;
                        end
                    end else if (ctrl_var16 && cnt == ABORT_LAST) begin
                        state <= CS_IDLE; // [R19]
                        dio.transfer_strobe <= 1'b0;
                        abort_flag <= 1'b1;
                    end
                end
                CS_HOLD: begin
                    cnt <= cnt + 10'h1;
                    if (cnt == HOLD_LAST) begin
                        state <= CS_RELEASE; // [R03]
                        dio.transfer_strobe <= 1'b0;
                    end
                end
                CS_RELEASE: begin
                    // stay busy until the unit lets go
                    if (!ack_s) begin // [R17]
                        state <= CS_IDLE;
                        done_flag <= 1'b1;
                    end
                end
                default: state <= CS_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- verif/dio_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module dio_checker #(
    parameter logic [15:0] UNIT_ADDR = 16'hF000
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // link
    input wire logic [15:0] address_lines,
    input wire logic direction_line,
    input wire logic [31:0] data_out,
    input wire logic [31:0] data_in,
    input wire logic transfer_strobe,
    input wire logic transfer_acknowledge,
    input wire logic status_bit_a_line,
    input wire logic status_bit_b_line,
    input wire logic io_reset_line,
    input wire logic free_running_clock_line
);
    logic [48:0] prev_lines;
    logic prev_clock;
    logic tick_seen;
    logic [7:0] line_age;
    logic [7:0] ack_age;
    logic [10:0] strobe_age;
    logic [4:0] tick_age;
    wire logic [48:0] lines = {address_lines, direction_line, data_out};
    wire logic lines_moved = lines != prev_lines;
    wire logic clock_moved = free_running_clock_line != prev_clock;

    // ages saturate so a stuck line cannot wrap back into the legal range
    always_ff @(posedge aclk) begin
        prev_lines <= lines;
        prev_clock <= free_running_clock_line;
        if (!aresetn) begin
            line_age <= 8'h00;
            ack_age <= 8'h00;
            strobe_age <= 11'h000;
            tick_age <= 5'h00;
            tick_seen <= 1'b0;
        end else begin
            line_age <= lines_moved ? 8'h00 :
                line_age + 8'(line_age != 8'hFF);
            ack_age <= !transfer_strobe ? 8'h00 :
                ack_age + 8'(transfer_acknowledge && ack_age != 8'hFF);
            strobe_age <= !transfer_strobe ? 11'h000 :
                strobe_age + 11'(strobe_age != 11'h7FF);
            tick_age <= clock_moved ? 5'h00 :
                tick_age + 5'(tick_age != 5'h1F);
            tick_seen <= tick_seen || clock_moved;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_setup_before_strobe: assert property (
        $rose(transfer_strobe) |-> line_age >= 8'h08 && !lines_moved)
        else $error("early strobe");
    a_lines_held: assert property (
        transfer_strobe && $past(transfer_strobe) |-> !lines_moved)
        else $error("lines moved");
    a_hold_after_ack: assert property (
        $fell(transfer_strobe) && ack_age != 8'h00 |-> ack_age >= 8'h08)
        else $error("short hold");
    a_strobe_until_ack: assert property (
        $fell(transfer_strobe) && ack_age == 8'h00
            |-> strobe_age >= 11'h3E7)
        else $error("early drop");
    a_ack_addressed: assert property (
        $rose(transfer_acknowledge)
            |-> transfer_strobe && address_lines == UNIT_ADDR)
        else $error("stray ack");
    a_unit_releases: assert property (
        $fell(transfer_strobe) |-> ##[0:5] (!transfer_acknowledge &&
            data_in == 32'h0 && !status_bit_a_line && !status_bit_b_line))
        else $error("unit kept link");
    a_status_with_ack: assert property (
        status_bit_a_line || status_bit_b_line || data_in != 32'h0
            |-> transfer_acknowledge)
        else $error("stray status");
    a_no_interrupt_read: assert property (
        transfer_strobe |-> address_lines[15:12] != 4'h1 || direction_line)
        else $error("interrupt read");
    a_clock_half_period: assert property (
        clock_moved && tick_seen |-> tick_age == 5'h0B)
        else $error("clock period");
    a_clock_keeps_running: assert property (
        tick_seen |-> tick_age <= 5'h0B)
        else $error("clock stalled");
endmodule
`default_nettype wire

// ---- verif/direct_io_strobe_handshake_port_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin \
    failures++; $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (got), \
    (exp)); end end
module direct_io_strobe_handshake_port_tb_top;
    import dio_pkg::*;
    localparam logic [15:0] UNIT_ADDR = 16'hF000;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic power_sequence = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [31:0] s_axi_araddr = 32'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] read_data = 32'h0;
    logic status_a = 1'b0, status_b = 1'b0;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire logic s_axi_arready, s_axi_rvalid;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata, u_wdata;
    wire logic u_valid, u_write, u_io_reset, u_tick;
    wire logic [15:0] u_addr;
    int failures = 0;
    int checks = 0;
    int sel_cnt = 0, stb_rises = 0, ticks = 0;
    logic stb_q = 1'b0;
    logic cap_write, cap_dir;
    logic [15:0] cap_addr, cap_a;
    logic [31:0] cap_wdata, cap_out;
    logic [31:0] mdl_rd = 32'h0;

    dio_if link();
    dio_cpu_end i_dio_cpu_end (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .power_sequence, .dio(link));
    dio_unit_end #(.UNIT_ADDR(UNIT_ADDR)) i_dio_unit_end (
        .aclk, .aresetn, .dio(link), .xfer_valid(u_valid),
        .xfer_write(u_write), .xfer_addr(u_addr), .xfer_wdata(u_wdata),
        .read_data, .status_a, .status_b, .io_reset(u_io_reset),
        .clock_tick(u_tick));
    dio_checker #(.UNIT_ADDR(UNIT_ADDR)) i_dio_checker (
        .aclk, .aresetn,
        .address_lines(link.address_lines),
        .direction_line(link.direction_line), .data_out(link.data_out),
        .data_in(link.data_in), .transfer_strobe(link.transfer_strobe),
        .transfer_acknowledge(link.transfer_acknowledge),
        .status_bit_a_line(link.status_bit_a_line),
        .status_bit_b_line(link.status_bit_b_line),
        .io_reset_line(link.io_reset_line),
        .free_running_clock_line(link.free_running_clock_line));

    always #(CLK_PERIOD_NS / 2) aclk = ~aclk;

    // what the cpu put out at strobe rise, and what the unit took
    always @(posedge aclk) begin
        stb_q <= link.transfer_strobe;
        if (link.transfer_strobe && !stb_q) begin
            stb_rises <= stb_rises + 1;
            cap_dir <= link.direction_line;
            cap_a <= link.address_lines;
            cap_out <= link.data_out;
        end
        if (u_valid) begin
            sel_cnt <= sel_cnt + 1;
            cap_write <= u_write;
            cap_addr <= u_addr;
            cap_wdata <= u_wdata;
        end
        if (u_tick) ticks <= ticks + 1;
    end

    task automatic results();
        if (failures == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // a task starts one edge late, so strobes never clash
    task automatic axi_wr(input logic [4:0] off, input logic [31:0] d,
        output logic [1:0] resp);
        @(posedge aclk);
        s_axi_awaddr <= {27'h0, off};
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic axi_rd(input logic [4:0] off, output logic [31:0] d,
        output logic [1:0] resp);
        @(posedge aclk);
        s_axi_araddr <= {27'h0, off};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                resp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask

    function automatic logic [31:0] exp_out(input logic [3:0] rf,
        input logic v16, input logic [31:0] d);
        if (rf == 4'h0) return 32'h0;
        return v16 ? {16'h0, d[15:0]} : d;
    endfunction

    // kind: 0 answered, 1 aborted, 2 refused
    task automatic do_xfer(input logic wr, input logic [3:0] rf,
        input logic v16, input logic [15:0] addr, input int kind);
        logic [31:0] wd, rdv, st, ctrl;
        logic [1:0] r, cc, s;
        int s0, r0;
        wd = $urandom;
        rdv = $urandom;
        s = 2'($urandom);
        ctrl = {24'h0, 1'b0, v16, rf, wr, 1'b1};
        read_data <= rdv;
        {status_b, status_a} <= s;
        axi_wr(REG_ADDR, {16'h0, addr}, r);
        axi_wr(REG_WDATA, wd, r);
        s0 = sel_cnt;
        r0 = stb_rises;
        axi_wr(REG_CTRL, ctrl, r);
        `CHK(r, RESP_OKAY)
        if (kind == 1) begin
            axi_wr(REG_ADDR, {16'h0, UNIT_ADDR}, r);
            axi_wr(REG_CTRL, ctrl, r);
        end
        do axi_rd(REG_STATUS, st, r);
        while (st[ST_BUSY] ||
                   !(st[ST_DONE] || st[ST_ABORT] || st[ST_REFUSED]));
        cc = v16 ? st[4:3] : st[2:1];
        if (kind == 2) begin
            `CHK(st[ST_REFUSED], 1'b1)
            `CHK(stb_rises - r0, 0)
        end else if (kind == 1) begin
            `CHK(st[ST_ABORT], 1'b1)
            `CHK(stb_rises - r0, 1)
            `CHK(sel_cnt - s0, 0)
            axi_rd(REG_ADDR, st, r);
            `CHK(st[15:0], addr)
        end else begin
            `CHK(st[ST_DONE], 1'b1)
            `CHK(cc, s)
            `CHK(sel_cnt - s0, 1)
            `CHK(cap_dir, wr)
            `CHK(cap_write, wr)
            `CHK(cap_a, addr)
            `CHK(cap_addr, addr)
            if (wr) begin
                `CHK(cap_out, exp_out(rf, v16, wd))
                `CHK(cap_wdata, exp_out(rf, v16, wd))
            end else begin
                mdl_rd = (rf == 4'h0) ? mdl_rd : exp_out(rf, v16, rdv);
                axi_rd(REG_RDATA, st, r);
                `CHK(st, mdl_rd)
            end
        end
    endtask

    initial begin
        #(CLK_PERIOD_NS * 40000);
        failures++;
        results();
    end

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [3:0] modes [5];
        int t0;
        modes = '{4'h0, 4'h1, 4'h2, 4'h7, 4'hF};
        void'($urandom(32));
        repeat (6) @(posedge aclk);
        `CHK(link.io_reset_line, 1'b1)
        aresetn <= 1'b1;
        axi_rd(REG_STATUS, d, r);
        `CHK(d, 32'h0)
        `CHK(link.io_reset_line, 1'b0)
        power_sequence <= 1'b1;
        repeat (5) @(posedge aclk);
        `CHK(link.io_reset_line, 1'b1)
        `CHK(u_io_reset, 1'b1)
        power_sequence <= 1'b0;
        axi_wr(REG_CTRL, 32'h80, r);
        repeat (5) @(posedge aclk);
        `CHK(link.io_reset_line, 1'b1)
        axi_wr(REG_CTRL, 32'h0, r);
        repeat (5) @(posedge aclk);
        `CHK(link.io_reset_line, 1'b0)
        `CHK(u_io_reset, 1'b0)
        t0 = ticks;
        repeat (240) @(posedge aclk);
        `CHK(ticks - t0, 10)
        axi_wr(5'h14, 32'hA5A5A5A5, r);
        `CHK(r, RESP_SLVERR)
        axi_rd(5'h14, d, r);
        `CHK(r, RESP_SLVERR)
        `CHK(d, 32'h0)
        do_xfer(1'b1, 4'h0, 1'b0, UNIT_ADDR, 0);
        do_xfer(1'b0, 4'h0, 1'b0, UNIT_ADDR, 0);
        do_xfer(1'b1, 4'h3, 1'b1, UNIT_ADDR, 0);
        do_xfer(1'b0, 4'h3, 1'b1, UNIT_ADDR, 0);
        do_xfer(1'b0, 4'h5, 1'b0, 16'h1234, 2);
        foreach (modes[i]) do_xfer(1'b1, 4'h1, 1'b1, {modes[i], 12'h123}, 1);
        repeat (8) begin
            do_xfer(1'($urandom), 4'($urandom), 1'($urandom), UNIT_ADDR, 0);
        end
        results();
    end
endmodule
`default_nettype wire
